// ===== inc/anpr_pkg.sv
`default_nettype none
package anpr_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [4:0] REG_LP_BASE = 5'h05;
    localparam logic [4:0] REG_EXPANSION = 5'h06;
    localparam logic [4:0] REG_NP_TX = 5'h07;
    localparam logic [4:0] REG_LP_NP = 5'h08;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_NEXT_PAGE = 15;
    localparam int BIT_ACK = 14;
    localparam int BIT_REMOTE_FAULT = 13;
    localparam int BIT_MSG_PAGE = 13;
    localparam int BIT_ACK2 = 12;
    localparam int BIT_TOGGLE = 11;
    localparam int BIT_EXP_PD_FAULT = 4;
    localparam int BIT_EXP_LP_NP_ABLE = 3;
    localparam int BIT_EXP_NP_ABLE = 2;
    localparam int BIT_EXP_PAGE_RX = 1;
    localparam int BIT_EXP_LP_AN_ABLE = 0;
    localparam int LATCH_PD_FAULT = 1;
    localparam int LATCH_PAGE_RX = 0;
    localparam int LATCH_COUNT = 2;

    // ------------------------------------------------------------
    // reset values and masks
    // ------------------------------------------------------------
    localparam logic [15:0] LP_BASE_RST = 16'h0001;
    localparam logic [15:0] LP_BASE_KEEP = 16'hafff;
    localparam logic [15:0] LP_NP_RST = 16'h0000;
    localparam logic [15:0] LP_NP_KEEP = 16'hbfff;
    localparam logic [15:0] NP_TX_RST = 16'h2001;
    localparam logic [15:0] NP_TX_WMASK = 16'hb7ff;

    // ------------------------------------------------------------
    // management frame
    // ------------------------------------------------------------
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [3:0] HDR_LAST = 4'hb;
    localparam logic [3:0] TA_LAST = 4'h1;
    localparam logic [3:0] DATA_LAST = 4'hf;

    typedef enum logic [2:0] {
        ANPR_IDLE,
        ANPR_START,
        ANPR_HDR,
        ANPR_TA,
        ANPR_DATA
    } anpr_mdio_state_t;
endpackage
`default_nettype wire

// ===== src/anpr_latch_hi.sv
`default_nettype none
module anpr_latch_hi #(
    parameter int N = 2
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // events and clear
    input wire logic [N-1:0] set_evt,
    input wire logic clr,
    // latched state
    output var logic [N-1:0] held
);
    // ------------------------------------------------------------
    // sticky bits, set wins over clear
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_bit
            always_ff @(posedge core_clk) begin
                if (srst) begin
                    held[i] <= 1'b0;
                end else begin
                    held[i] <= set_evt[i] | (held[i] & ~clr);
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ===== src/anpr_page_regs.sv
// Functional notes
// - partner base next-page bit, read-only, reset zero
// - partner acknowledge set on received code word
// - partner remote fault shown read-only
// - partner pause two-bit field at 11:10
// - partner technology bits 9 to 5
// - partner selector 4:0, default 00001
// - parallel detect fault latches until read
// - expansion shows partner next-page ability
// - local next-page able reads one
// - page received latches until read
// - partner auto-negotiation able, default zero
// - acknowledge 2 writable, reset zero
// - transmit toggle read-only, previous word toggle
// - partner next page stored, acknowledge on receipt
// - partner acknowledge 2 read-only
// - partner toggle shown read-only
`default_nettype none
module anpr_page_regs (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // management serial port
    input wire logic mdc,
    input wire logic mdio_in,
    output var logic mdio_out,
    output var logic mdio_oe,
    input wire logic [4:0] phy_addr,
    // pages received from the partner
    input wire logic base_page_valid,
    input wire logic [15:0] base_page_word,
    input wire logic next_page_valid,
    input wire logic [15:0] next_page_word,
    input wire logic partner_an_able,
    input wire logic pd_fault,
    // local next page toward the arbitration
    input wire logic tx_page_sent,
    output var logic [15:0] tx_page_word,
    output var logic tx_page_pending
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    anpr_pkg::anpr_mdio_state_t state_q;
    logic mdc_prev_q;
    logic mdc_rise;
    logic [3:0] cnt_q;
    logic [10:0] hdr_q;
    logic [11:0] hdr_full;
    logic [15:0] rd_shift_q;
    logic [14:0] wr_shift_q;
    logic drive_q;
    logic wr_hit_q;
    logic [4:0] wr_addr_q;
    logic [4:0] hdr_addr;
    logic hdr_mine;
    logic hdr_mapped;
    logic rd_start;
    logic rd_clr_exp;
    logic wr_strobe;
    logic [15:0] wr_data;
    logic [15:0] lp_base_q;
    logic [15:0] lp_np_q;
    logic [15:0] np_tx_q;
    logic lp_np_able_q;
    logic lp_an_able_q;
    logic [anpr_pkg::LATCH_COUNT-1:0] latch_set;
    logic [anpr_pkg::LATCH_COUNT-1:0] latch_q;
    logic [15:0] exp_word;
    logic [15:0] rd_word;
    logic hdr_rise;
    logic hdr_end;
    logic op_known;
    logic wr_claim;
    logic in_ta_rise;
    logic in_data_rise;
    logic data_end;
    logic shift_out;
    logic np_wr;

    // ------------------------------------------------------------
    // management clock edge
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            mdc_prev_q <= 1'b0;
        end else begin
            mdc_prev_q <= mdc;
        end
    end

    assign mdc_rise = mdc & ~mdc_prev_q;

    // ------------------------------------------------------------
    // frame header decode
    // ------------------------------------------------------------
    assign hdr_full = {hdr_q, mdio_in};
    assign hdr_addr = hdr_full[4:0];
    assign hdr_mine = (hdr_full[9:5] == phy_addr);
    assign hdr_mapped = (hdr_addr == anpr_pkg::REG_LP_BASE) ||
                        (hdr_addr == anpr_pkg::REG_EXPANSION) ||
                        (hdr_addr == anpr_pkg::REG_NP_TX) ||
                        (hdr_addr == anpr_pkg::REG_LP_NP);
    assign hdr_rise = mdc_rise && (state_q == anpr_pkg::ANPR_HDR);
    assign hdr_end = hdr_rise && (cnt_q == anpr_pkg::HDR_LAST);
    assign op_known = (hdr_full[11:10] == anpr_pkg::OP_READ) ||
                      (hdr_full[11:10] == anpr_pkg::OP_WRITE);
    assign rd_start = hdr_end && (hdr_full[11:10] == anpr_pkg::OP_READ) &&
                      hdr_mine && hdr_mapped;
    assign wr_claim = (hdr_full[11:10] == anpr_pkg::OP_WRITE) && hdr_mine && hdr_mapped;
    assign rd_clr_exp = rd_start && (hdr_addr == anpr_pkg::REG_EXPANSION);
    assign in_ta_rise = mdc_rise && (state_q == anpr_pkg::ANPR_TA);
    assign in_data_rise = mdc_rise && (state_q == anpr_pkg::ANPR_DATA);
    assign data_end = in_data_rise && (cnt_q == anpr_pkg::DATA_LAST);
    assign wr_data = {wr_shift_q, mdio_in};
    assign wr_strobe = data_end && wr_hit_q;
    assign np_wr = wr_strobe && (wr_addr_q == anpr_pkg::REG_NP_TX);

    // ------------------------------------------------------------
    // frame sequencer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_q <= anpr_pkg::ANPR_IDLE;
            cnt_q <= 4'h0;
        end else if (mdc_rise) begin
            case (state_q)
                anpr_pkg::ANPR_IDLE: begin
                    if (!mdio_in) begin
                        state_q <= anpr_pkg::ANPR_START;
                    end
                end
                anpr_pkg::ANPR_START: begin
                    cnt_q <= 4'h0;
                    state_q <= mdio_in ? anpr_pkg::ANPR_HDR : anpr_pkg::ANPR_IDLE;
                end
                anpr_pkg::ANPR_HDR: begin
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == anpr_pkg::HDR_LAST) begin
                        cnt_q <= 4'h0;
                        state_q <= op_known ? anpr_pkg::ANPR_TA : anpr_pkg::ANPR_IDLE;
                    end
                end
                anpr_pkg::ANPR_TA: begin
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == anpr_pkg::TA_LAST) begin
                        cnt_q <= 4'h0;
                        state_q <= anpr_pkg::ANPR_DATA;
                    end
                end
                anpr_pkg::ANPR_DATA: begin
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == anpr_pkg::DATA_LAST) begin
                        cnt_q <= 4'h0;
                        state_q <= anpr_pkg::ANPR_IDLE;
                    end
                end
                default: begin
                    state_q <= anpr_pkg::ANPR_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // header capture and frame role
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            hdr_q <= 11'h000;
        end else if (hdr_rise) begin
            hdr_q <= hdr_full[10:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            drive_q <= 1'b0;
            wr_hit_q <= 1'b0;
            wr_addr_q <= 5'h00;
        end else if (hdr_end) begin
            drive_q <= rd_start;
            wr_hit_q <= wr_claim;
            wr_addr_q <= hdr_addr;
        end else if (data_end) begin
            drive_q <= 1'b0;
            wr_hit_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // write data capture
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            wr_shift_q <= 15'h0000;
        end else if (in_data_rise) begin
            wr_shift_q <= wr_data[14:0];
        end
    end

    // ------------------------------------------------------------
    // read data and serial output
    // ------------------------------------------------------------
    always_comb begin
        case (hdr_addr)
            anpr_pkg::REG_LP_BASE: rd_word = lp_base_q;
            anpr_pkg::REG_EXPANSION: rd_word = exp_word;
            anpr_pkg::REG_NP_TX: rd_word = np_tx_q;
            anpr_pkg::REG_LP_NP: rd_word = lp_np_q;
            default: rd_word = 16'h0000;
        endcase
    end

    assign shift_out = drive_q && ((in_ta_rise && (cnt_q == anpr_pkg::TA_LAST)) ||
                       (in_data_rise && (cnt_q != anpr_pkg::DATA_LAST)));

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rd_shift_q <= 16'h0000;
        end else if (rd_start) begin
            rd_shift_q <= rd_word;
        end else if (shift_out) begin
            rd_shift_q <= {rd_shift_q[14:0], 1'b0};
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            mdio_oe <= 1'b0;
        end else if (drive_q && in_ta_rise && (cnt_q != anpr_pkg::TA_LAST)) begin
            mdio_oe <= 1'b1;
        end else if (drive_q && data_end) begin
            mdio_oe <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            mdio_out <= 1'b0;
        end else if (shift_out) begin
            mdio_out <= rd_shift_q[15];
        end else if (drive_q && (in_ta_rise || in_data_rise)) begin
            mdio_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // partner base page
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            lp_base_q <= anpr_pkg::LP_BASE_RST;
            lp_np_able_q <= 1'b0;
        end else if (base_page_valid) begin
            lp_base_q <= base_page_word & anpr_pkg::LP_BASE_KEEP;
            lp_base_q[anpr_pkg::BIT_ACK] <= 1'b1;
            lp_np_able_q <= base_page_word[anpr_pkg::BIT_NEXT_PAGE];
        end
    end

    // ------------------------------------------------------------
    // partner next page
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            lp_np_q <= anpr_pkg::LP_NP_RST;
        end else if (next_page_valid) begin
            lp_np_q <= next_page_word & anpr_pkg::LP_NP_KEEP;
            lp_np_q[anpr_pkg::BIT_ACK] <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // expansion status
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            lp_an_able_q <= 1'b0;
        end else begin
            lp_an_able_q <= partner_an_able;
        end
    end

    assign latch_set[anpr_pkg::LATCH_PD_FAULT] = pd_fault;
    assign latch_set[anpr_pkg::LATCH_PAGE_RX] = base_page_valid | next_page_valid;

    anpr_latch_hi #(
        .N(anpr_pkg::LATCH_COUNT)
    ) u_latch (
        .core_clk(core_clk),
        .srst(srst),
        .set_evt(latch_set),
        .clr(rd_clr_exp),
        .held(latch_q)
    );

    always_comb begin
        exp_word = 16'h0000;
        exp_word[anpr_pkg::BIT_EXP_PD_FAULT] = latch_q[anpr_pkg::LATCH_PD_FAULT];
        exp_word[anpr_pkg::BIT_EXP_LP_NP_ABLE] = lp_np_able_q;
        exp_word[anpr_pkg::BIT_EXP_NP_ABLE] = 1'b1;
        exp_word[anpr_pkg::BIT_EXP_PAGE_RX] = latch_q[anpr_pkg::LATCH_PAGE_RX];
        exp_word[anpr_pkg::BIT_EXP_LP_AN_ABLE] = lp_an_able_q;
    end

    // ------------------------------------------------------------
    // local next page
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            np_tx_q <= anpr_pkg::NP_TX_RST;
        end else begin
            if (np_wr) begin
                np_tx_q <= (wr_data & anpr_pkg::NP_TX_WMASK) |
                           (np_tx_q & ~anpr_pkg::NP_TX_WMASK);
            end
            if (tx_page_sent) begin
                np_tx_q[anpr_pkg::BIT_TOGGLE] <= ~np_tx_q[anpr_pkg::BIT_TOGGLE];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            tx_page_word <= anpr_pkg::NP_TX_RST;
        end else begin
            tx_page_word <= np_tx_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            tx_page_pending <= 1'b0;
        end else if (np_wr) begin
            tx_page_pending <= 1'b1;
        end else if (tx_page_sent) begin
            tx_page_pending <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== testbench/anpr_page_regs_monitor.sv
`default_nettype none
module anpr_page_regs_monitor (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // watched ports
    input wire logic mdc,
    input wire logic mdio_out,
    input wire logic mdio_oe,
    input wire logic tx_page_sent,
    input wire logic [15:0] tx_page_word,
    input wire logic tx_page_pending
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    // ------------------------------------------------------------
    // steps of a read answer, and local next-page pending and toggle
    // ------------------------------------------------------------
    sequence s_mdc_rise;
        $past(mdc) && (!$past(mdc, 2) || !$past(mdc, 3));
    endsequence
    sequence s_ta_drive;
        !mdio_out ##1 mdio_oe [*7];
    endsequence
    a_ta_drive: assert property ($rose(mdio_oe) |-> s_ta_drive)
        else $error("turnaround drive wrong");
    a_oe_start: assert property ($rose(mdio_oe) |-> s_mdc_rise)
        else $error("drive began off a clock rise");
    a_oe_end: assert property ($fell(mdio_oe) |-> s_mdc_rise)
        else $error("drive ended off a clock rise");
    a_out_on_rise: assert property (mdio_oe && $changed(mdio_out) |-> s_mdc_rise)
        else $error("data changed off a clock rise");
    a_pend_set: assert property ($rose(tx_page_pending) |-> s_mdc_rise)
        else $error("pending rose without a frame end");
    a_pend_clear: assert property (tx_page_sent |=> !tx_page_pending)
        else $error("pending kept after page sent");
    a_toggle_flip: assert property (tx_page_sent |-> ##2
        tx_page_word[11] != $past(tx_page_word[11], 2))
        else $error("toggle did not invert");
    a_wr_only: assert property ($changed(tx_page_word & 16'hb7ff) |-> ##[0:1]
        tx_page_pending)
        else $error("page word changed without a write");
    a_rsvd_zero: assert property (tx_page_word[14] == 1'b0)
        else $error("reserved page bit set");
endmodule
bind anpr_page_regs anpr_page_regs_monitor mon_u (
    .core_clk(core_clk),
    .srst(srst),
    .mdc(mdc),
    .mdio_out(mdio_out),
    .mdio_oe(mdio_oe),
    .tx_page_sent(tx_page_sent),
    .tx_page_word(tx_page_word),
    .tx_page_pending(tx_page_pending)
);
`default_nettype wire

// ===== testbench/anpr_smi_master.sv
`default_nettype none
module anpr_smi_master (
    // clock
    input wire logic core_clk,
    // management wire
    output var logic mdc,
    output var logic md_oe,
    output var logic md_out,
    input wire logic md_wire
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        mdc = 1'b0;
        md_oe = 1'b0;
        md_out = 1'b0;
    end
    task automatic half();
        repeat (3) @(negedge core_clk);
    endtask
    // start, op, station, register, turnaround, data; three core cycles a phase
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [31:0] f;
        f = {2'h1, op, phy, rg, 2'h2, wd};
        rd = 16'h0000;
        for (int k = 0; k < 32; k++) begin
            md_oe = (op != anpr_pkg::OP_READ) || (k < 14);
            md_out = f[31-k];
            half();
            if (k >= 16) begin
                rd[31-k] = md_wire;
            end
            mdc = 1'b1;
            half();
            mdc = 1'b0;
        end
        md_oe = 1'b0;
        @(negedge core_clk);
    endtask
endmodule
`default_nettype wire

// ===== testbench/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] ADDR = 5'h03;
    logic core_clk, srst, mdc, mdio_out, mdio_oe, m_oe, m_out, mdio_w;
    logic base_page_valid, next_page_valid, partner_an_able, pd_fault;
    logic tx_page_sent, tx_page_pending;
    logic [15:0] base_page_word, next_page_word, tx_page_word, rd_v;
    int fails = 0;
    int n_tests = 0;
    // pulled-up wire
    assign mdio_w = mdio_oe ? mdio_out : (m_oe ? m_out : 1'b1);
    anpr_page_regs dut_u (.core_clk(core_clk), .srst(srst), .mdc(mdc), .mdio_in(mdio_w),
        .mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_addr(ADDR),
        .base_page_valid(base_page_valid), .base_page_word(base_page_word),
        .next_page_valid(next_page_valid), .next_page_word(next_page_word),
        .partner_an_able(partner_an_able), .pd_fault(pd_fault),
        .tx_page_sent(tx_page_sent), .tx_page_word(tx_page_word),
        .tx_page_pending(tx_page_pending));
    anpr_smi_master smi_u (.core_clk(core_clk), .mdc(mdc), .md_oe(m_oe), .md_out(m_out),
        .md_wire(mdio_w));
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("fails %0d n_tests %0d", fails, n_tests);
        if (fails == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic rd_chk(input logic [4:0] phy, input logic [4:0] rg, input logic [15:0] exp);
        logic [15:0] v;
        smi_u.frame(anpr_pkg::OP_READ, phy, rg, 16'h0000, v);
        check(v, exp);
    endtask
    task automatic wr(input logic [4:0] phy, input logic [4:0] rg, input logic [15:0] d);
        logic [15:0] v;
        smi_u.frame(anpr_pkg::OP_WRITE, phy, rg, d, v);
    endtask
    task automatic pulse(ref logic s);
        @(negedge core_clk);
        s = 1'b1;
        @(negedge core_clk);
        s = 1'b0;
        @(negedge core_clk);
    endtask
    initial begin
        repeat (60000) @(posedge core_clk);
        fails++;
        finish_test();
    end
    initial begin
        srst = 1'b1;
        {base_page_valid, next_page_valid, partner_an_able, pd_fault, tx_page_sent} = 5'h00;
        base_page_word = 16'h0000;
        next_page_word = 16'h0000;
        repeat (5) @(negedge core_clk);
        srst = 1'b0;
        check(tx_page_word, 16'h2001);
        check({15'h0000, tx_page_pending}, 16'h0000);
        rd_chk(ADDR, anpr_pkg::REG_LP_BASE, 16'h0001);
        rd_chk(ADDR, anpr_pkg::REG_EXPANSION, 16'h0004);
        rd_chk(ADDR, anpr_pkg::REG_NP_TX, 16'h2001);
        rd_chk(ADDR, anpr_pkg::REG_LP_NP, 16'h0000);
        rd_chk(ADDR, 5'h04, 16'hffff);
        rd_chk(ADDR ^ 5'h01, anpr_pkg::REG_LP_BASE, 16'hffff);
        wr(ADDR, anpr_pkg::REG_LP_BASE, 16'h0000);
        rd_chk(ADDR, anpr_pkg::REG_LP_BASE, 16'h0001);
        partner_an_able = 1'b1;
        for (int c = 0; c < 4; c++) begin
            base_page_word = {4'hb, c[1:0], 10'h3e1};
            pulse(base_page_valid);
            rd_chk(ADDR, anpr_pkg::REG_LP_BASE, {4'he, c[1:0], 10'h3e1});
        end
        pulse(pd_fault);
        rd_chk(ADDR, anpr_pkg::REG_EXPANSION, 16'h001f);
        rd_chk(ADDR, anpr_pkg::REG_EXPANSION, 16'h000d);
        next_page_word = 16'h3aaa;
        pulse(next_page_valid);
        rd_chk(ADDR, anpr_pkg::REG_LP_NP, 16'h7aaa);
        rd_chk(ADDR, anpr_pkg::REG_EXPANSION, 16'h000f);
        wr(ADDR, anpr_pkg::REG_NP_TX, 16'hffff);
        check({15'h0000, tx_page_pending}, 16'h0001);
        check(tx_page_word, 16'hb7ff);
        rd_chk(ADDR, anpr_pkg::REG_NP_TX, 16'hb7ff);
        pulse(tx_page_sent);
        check({15'h0000, tx_page_pending}, 16'h0000);
        rd_chk(ADDR, anpr_pkg::REG_NP_TX, 16'hbfff);
        wr(ADDR ^ 5'h01, anpr_pkg::REG_NP_TX, 16'h0000);
        wr(ADDR, anpr_pkg::REG_NP_TX, 16'h4800);
        rd_chk(ADDR, anpr_pkg::REG_NP_TX, 16'h0800);
        pulse(tx_page_sent);
        rd_chk(ADDR, anpr_pkg::REG_NP_TX, 16'h0000);
        smi_u.frame(2'h3, ADDR, anpr_pkg::REG_NP_TX, 16'hffff, rd_v);
        rd_chk(ADDR, anpr_pkg::REG_NP_TX, 16'h0000);
        check({15'h0000, tx_page_pending}, 16'h0000);
        wr(ADDR, anpr_pkg::REG_NP_TX, 16'h8000);
        check(tx_page_word, 16'h8000);
        check({15'h0000, tx_page_pending}, 16'h0001);
        srst = 1'b1;
        repeat (5) @(negedge core_clk);
        srst = 1'b0;
        check(tx_page_word, 16'h2001);
        check({15'h0000, tx_page_pending}, 16'h0000);
        rd_chk(ADDR, anpr_pkg::REG_LP_BASE, 16'h0001);
        rd_chk(ADDR, anpr_pkg::REG_EXPANSION, 16'h0005);
        rd_chk(ADDR, anpr_pkg::REG_LP_NP, 16'h0000);
        finish_test();
    end
endmodule
`default_nettype wire
